// ### src/usp_top.sv
// Serial port with AHB-Lite register slave, interrupt and line logic
`timescale 1ns/1ps
`default_nettype none
module usp_top #(
	parameter int unsigned CLK_HZ = usp_pkg::USP_CLK_HZ
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire usp_pkg::usp_ahb_req_s ahb_req,
	output usp_pkg::usp_ahb_rsp_s ahb_rsp,
	input wire logic rx_pin,
	output logic tx_out,
	output logic tx_oe,
	output logic port_active,
	output logic irq
);
	import usp_pkg::*;

	localparam usp_div_t DIV_TAB = usp_div_table(CLK_HZ);

	usp_state_s s_reg;
	usp_state_s s_next;
	logic rx_level;

	usp_sync3 u_rx_sync (
		.hclk(hclk),
		.hresetn(hresetn),
		.din(rx_pin),
		.dout(rx_level)
	);

	function automatic logic [31:0] byte_addr(input logic [15:0] idx);
		return {14'h0000, idx, 2'b00};
	endfunction

	logic en;
	logic [2:0] baud_code;
	logic [15:0] div_last;
	logic div_wrap;
	logic acc;
	logic rd;
	logic [31:0] addr;
	logic ev_tx_empty;
	logic ev_rx_full;

	always_comb begin
		s_next = s_reg;
		en = s_reg.ctrl[USP_CTRL_EN];
		baud_code = s_reg.ctrl[USP_CTRL_BAUD_LO +: 3];
		div_last = DIV_TAB[baud_code];
		div_wrap = 1'b0;
		acc = ahb_req.hsel && ahb_req.hready && (ahb_req.htrans == USP_HTRANS_NONSEQ);
		rd = acc && !ahb_req.hwrite;
		addr = ahb_req.haddr;
		ev_tx_empty = 1'b0;
		ev_rx_full = 1'b0;

		// Oversampling tick: sixteen per bit, optionally one in eight kept
		s_next.tick = 1'b0;
		if (!en) begin
			s_next.div_cnt = 16'h0000;
			s_next.pre_cnt = 3'h0;
		end else if (s_reg.div_cnt >= div_last) begin
			s_next.div_cnt = 16'h0000;
			div_wrap = 1'b1;
		end else begin
			s_next.div_cnt = s_reg.div_cnt + 16'h0001;
		end
		if (div_wrap) begin
			s_next.pre_cnt = s_reg.pre_cnt + 3'h1;
			s_next.tick = !s_reg.ctrl[USP_CTRL_PRE] || (s_reg.pre_cnt == USP_PRE_LAST);
		end

		// Transmitter
		if (!en) begin
			s_next.tx_busy = 1'b0;
			s_next.tx_sub = 4'h0;
			s_next.tx_bit = 4'h0;
		end else if (s_reg.tx_busy && s_reg.tick) begin
			s_next.tx_sub = s_reg.tx_sub + 4'h1;
			if (s_reg.tx_sub == USP_SUB_LAST) begin
				s_next.tx_sh = {1'b1, s_reg.tx_sh[9:1]};
				s_next.tx_bit = s_reg.tx_bit + 4'h1;
				if (s_reg.tx_bit == USP_TX_BITS - 4'h1) begin
					s_next.tx_busy = 1'b0;
				end
			end
		end

		// Receiver, sampling mid-bit
		if (!en) begin
			s_next.rx_st = USP_RX_IDLE;
		end else begin
			case (s_reg.rx_st)
				USP_RX_IDLE: begin
					s_next.rx_sub = 4'h0;
					if (!rx_level) begin
						s_next.rx_st = USP_RX_START;
					end
				end
				USP_RX_START: begin
					if (s_reg.tick) begin
						s_next.rx_sub = s_reg.rx_sub + 4'h1;
						if (s_reg.rx_sub == USP_SUB_MID) begin
							s_next.rx_sub = 4'h0;
							s_next.rx_bit = 3'h0;
							// Glitch shorter than half a bit is not a start
							s_next.rx_st = rx_level ? USP_RX_IDLE : USP_RX_DATA;
						end
					end
				end
				USP_RX_DATA: begin
					if (s_reg.tick) begin
						s_next.rx_sub = s_reg.rx_sub + 4'h1;
						if (s_reg.rx_sub == USP_SUB_LAST) begin
							s_next.rx_sh = {rx_level, s_reg.rx_sh[7:1]};
							s_next.rx_bit = s_reg.rx_bit + 3'h1;
							if (s_reg.rx_bit == USP_RX_LAST_BIT) begin
								s_next.rx_st = USP_RX_STOP;
							end
						end
					end
				end
				USP_RX_STOP: begin
					if (s_reg.tick) begin
						s_next.rx_sub = s_reg.rx_sub + 4'h1;
						if (s_reg.rx_sub == USP_SUB_LAST) begin
							s_next.rx_st = USP_RX_IDLE;
							// Framing error drops the byte; an unread byte is overwritten
							if (rx_level) begin
								ev_rx_full = 1'b1;
							end
						end
					end
				end
				default: begin
					s_next.rx_st = USP_RX_IDLE;
				end
			endcase
		end

		// Bus data phase: write takes hwdata one cycle after its address phase
		s_next.wsel = USP_W_NONE;
		case (s_reg.wsel)
			USP_W_CTRL: begin
				s_next.ctrl = ahb_req.hwdata[4:0];
			end
			USP_W_IMASK: begin
				s_next.imask = ahb_req.hwdata[1:0];
			end
			USP_W_DATA: begin
				// Refused while busy or disabled so an in-flight byte is never corrupted
				if (en && !s_reg.tx_busy) begin
					s_next.tx_sh = {1'b1, ahb_req.hwdata[7:0], 1'b0};
					s_next.tx_busy = 1'b1;
					s_next.tx_sub = 4'h0;
					s_next.tx_bit = 4'h0;
				end
			end
			default: begin
			end
		endcase

		// Bus address phase: read data registered for the data phase
		s_next.rsp.hrdata = 32'h00000000;
		if (acc) begin
			if (addr == byte_addr(USP_IDX_CTRL)) begin
				if (ahb_req.hwrite) begin
					s_next.wsel = USP_W_CTRL;
				end else begin
					s_next.rsp.hrdata = {27'h0000000, s_reg.ctrl};
				end
			end else if (addr == byte_addr(USP_IDX_STAT)) begin
				s_next.rsp.hrdata = {30'h00000000, s_reg.rx_full, s_reg.tx_busy};
			end else if (addr == byte_addr(USP_IDX_DATA)) begin
				if (ahb_req.hwrite) begin
					s_next.wsel = USP_W_DATA;
				end else begin
					s_next.rsp.hrdata = {24'h000000, s_reg.rx_data};
				end
			end else if (addr == byte_addr(USP_IDX_ISTAT)) begin
				s_next.rsp.hrdata = {30'h00000000, s_reg.istat};
			end else if (addr == byte_addr(USP_IDX_IMASK)) begin
				if (ahb_req.hwrite) begin
					s_next.wsel = USP_W_IMASK;
				end else begin
					s_next.rsp.hrdata = {30'h00000000, s_reg.imask};
				end
			end
		end

		// Receive buffer: a new byte wins over a clearing read in the same cycle
		if (rd && addr == byte_addr(USP_IDX_DATA)) begin
			s_next.rx_full = 1'b0;
		end
		if (ev_rx_full) begin
			s_next.rx_data = s_reg.rx_sh;
			s_next.rx_full = 1'b1;
		end
		if (!en) begin
			s_next.rx_full = 1'b0;
		end

		ev_tx_empty = s_reg.tx_busy && !s_next.tx_busy;

		// Sticky events, read-to-clear, set wins
		if (rd && addr == byte_addr(USP_IDX_ISTAT)) begin
			s_next.istat = 2'h0;
		end
		if (ev_tx_empty) begin
			s_next.istat[USP_ST_TXFULL] = 1'b1;
		end
		if (ev_rx_full) begin
			s_next.istat[USP_ST_RXFULL] = 1'b1;
		end
		s_next.irq = |(s_next.istat & s_next.imask);

		s_next.tx_line = s_next.tx_busy ? s_next.tx_sh[0] : 1'b1;
		s_next.tx_oe = s_next.ctrl[USP_CTRL_EN];
		s_next.rsp.hreadyout = 1'b1;
		s_next.rsp.hresp = 1'b0;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_reg <= '0;
			s_reg.rsp.hreadyout <= 1'b1;
			s_reg.ctrl <= USP_CTRL_RESET;
			s_reg.imask <= USP_IMASK_RESET;
			s_reg.rx_st <= USP_RX_IDLE;
			s_reg.wsel <= USP_W_NONE;
			s_reg.tx_line <= 1'b1;
			s_reg.tx_oe <= USP_CTRL_RESET[USP_CTRL_EN];
		end else begin
			s_reg <= s_next;
		end
	end

	assign ahb_rsp = s_reg.rsp;
	assign tx_out = s_reg.tx_line;
	assign tx_oe = s_reg.tx_oe;
	assign port_active = s_reg.tx_oe;
	assign irq = s_reg.irq;
endmodule
`default_nettype wire

// ### src/usp_pkg.sv
// Shared constants, types and state layout of the serial port block
package usp_pkg;

	localparam int unsigned USP_CLK_HZ = 250_000_000;
	localparam int unsigned USP_OVERSAMPLE = 16;

	// Offsets are register indices; byte address is four times the index
	localparam logic [15:0] USP_IDX_CTRL = 16'hC0E0;
	localparam logic [15:0] USP_IDX_STAT = 16'hC0E2;
	localparam logic [15:0] USP_IDX_DATA = 16'hC0E4;
	localparam logic [15:0] USP_IDX_ISTAT = 16'hC0E6;
	localparam logic [15:0] USP_IDX_IMASK = 16'hC0E8;

	localparam int USP_CTRL_EN = 0;
	localparam int USP_CTRL_BAUD_LO = 1;
	localparam int USP_CTRL_PRE = 4;
	localparam logic [4:0] USP_CTRL_RESET = 5'h07;
	localparam int USP_ST_TXFULL = 0;
	localparam int USP_ST_RXFULL = 1;
	localparam logic [1:0] USP_IMASK_RESET = 2'h0;

	localparam logic [3:0] USP_SUB_MID = 4'h7;
	localparam logic [3:0] USP_SUB_LAST = 4'hF;
	localparam logic [3:0] USP_TX_BITS = 4'hA;
	localparam logic [2:0] USP_RX_LAST_BIT = 3'h7;
	localparam logic [2:0] USP_PRE_LAST = 3'h7;
	localparam logic [1:0] USP_HTRANS_NONSEQ = 2'h2;

	typedef logic [7:0][31:0] usp_baud_t;
	typedef logic [7:0][15:0] usp_div_t;

	// Rates for baud codes 0 to 7 without the divide-by-eight prescaler
	localparam usp_baud_t USP_BAUD = {32'h00001C20, 32'h00002580, 32'h00003840, 32'h00004B00,
		32'h00007080, 32'h00009600, 32'h0000E100, 32'h0001C200};

	// Terminal counts of the oversampling divider, one per baud code
	function automatic usp_div_t usp_div_table(input int unsigned clk_hz);
		usp_div_t t;
		for (int i = 0; i < 8; i++) begin
			t[i] = 16'(clk_hz / (USP_BAUD[i] * USP_OVERSAMPLE) - 1);
		end
		return t;
	endfunction

	typedef struct packed {
		logic hsel;
		logic [31:0] haddr;
		logic [1:0] htrans;
		logic hwrite;
		logic [2:0] hsize;
		logic hready;
		logic [31:0] hwdata;
	} usp_ahb_req_s;

	typedef struct packed {
		logic [31:0] hrdata;
		logic hreadyout;
		logic hresp;
	} usp_ahb_rsp_s;

	typedef enum logic [1:0] {
		USP_RX_IDLE = 2'b00,
		USP_RX_START = 2'b01,
		USP_RX_DATA = 2'b11,
		USP_RX_STOP = 2'b10
	} usp_rx_e;

	typedef enum logic [2:0] {
		USP_W_NONE = 3'h0,
		USP_W_CTRL = 3'h1,
		USP_W_DATA = 3'h2,
		USP_W_IMASK = 3'h3
	} usp_wsel_e;

	typedef struct packed {
		logic [2:0] pipe;
		logic level;
	} usp_sync_s;

	typedef struct packed {
		usp_ahb_rsp_s rsp;
		usp_wsel_e wsel;
		logic [4:0] ctrl;
		logic [1:0] istat;
		logic [1:0] imask;
		logic irq;
		logic [15:0] div_cnt;
		logic [2:0] pre_cnt;
		logic tick;
		logic tx_busy;
		logic [9:0] tx_sh;
		logic [3:0] tx_sub;
		logic [3:0] tx_bit;
		logic tx_line;
		logic tx_oe;
		usp_rx_e rx_st;
		logic [3:0] rx_sub;
		logic [2:0] rx_bit;
		logic [7:0] rx_sh;
		logic [7:0] rx_data;
		logic rx_full;
	} usp_state_s;

endpackage

// ### src/usp_sync3.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module usp_sync3 (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic din,
	output logic dout
);
	import usp_pkg::*;

	usp_sync_s s_reg;
	usp_sync_s s_next;

	// First stage feeds only the second; level moves once stages two and three agree
	always_comb begin
		s_next = s_reg;
		s_next.pipe = {s_reg.pipe[1:0], din};
		if (s_reg.pipe[1] == s_reg.pipe[2]) begin
			s_next.level = s_reg.pipe[2];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_reg <= '{pipe: 3'h7, level: 1'b1};
		end else begin
			s_reg <= s_next;
		end
	end

	assign dout = s_reg.level;
endmodule
`default_nettype wire

// ### tb/usp_top_sva.sv
// Checker for the serial port bus and line ports
`timescale 1ns/1ps
`default_nettype none
module usp_top_sva #(
	parameter int unsigned CLK_HZ = usp_pkg::USP_CLK_HZ
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire usp_pkg::usp_ahb_req_s ahb_req,
	input wire usp_pkg::usp_ahb_rsp_s ahb_rsp,
	input wire logic rx_pin,
	input wire logic tx_out,
	input wire logic tx_oe,
	input wire logic port_active,
	input wire logic irq
);
	import usp_pkg::*;
	localparam logic [31:0] A_C = {14'h0, USP_IDX_CTRL, 2'h0};
	localparam logic [31:0] A_S = {14'h0, USP_IDX_STAT, 2'h0};
	localparam logic [31:0] A_D = {14'h0, USP_IDX_DATA, 2'h0};
	localparam logic [31:0] A_M = {14'h0, USP_IDX_IMASK, 2'h0};
	logic pv;
	logic pw;
	logic [31:0] pa;
	logic [1:0] msk;
	// Mirror of the mask, updated at the same edge as the slave's copy
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pv <= 1'b0;
			pw <= 1'b0;
			pa <= 32'h0;
			msk <= 2'h0;
		end else begin
			pv <= ahb_req.hsel && ahb_req.hready && ahb_req.htrans == USP_HTRANS_NONSEQ;
			pw <= ahb_req.hwrite;
			pa <= ahb_req.haddr;
			if (pv && pw && pa == A_M) begin
				msk <= ahb_req.hwdata[1:0];
			end
		end
	end
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	property p_rsp; ahb_rsp.hreadyout && !ahb_rsp.hresp; endproperty
	a_rsp: assert property (p_rsp) else $error("bus slave stalled or answered an error");
	property p_en; pv && pw && pa == A_C |=> port_active == $past(ahb_req.hwdata[0]); endproperty
	a_en: assert property (p_en) else $error("enable does not follow control write");
	property p_oe; tx_oe == port_active && (tx_oe || tx_out); endproperty
	a_oe: assert property (p_oe) else $error("pin drive differs from enable or released line not idle");
	property p_stat; pv && !pw && pa == A_S |-> ahb_rsp.hrdata[31:2] == 30'h0; endproperty
	a_stat: assert property (p_stat) else $error("status upper bits not zero");
	property p_data; pv && !pw && pa == A_D |-> ahb_rsp.hrdata[31:8] == 24'h0; endproperty
	a_data: assert property (p_data) else $error("data upper bits not zero");
	property p_unm; pv && !pw && pa == 32'h000303A4 |-> ahb_rsp.hrdata == 32'h0; endproperty
	a_unm: assert property (p_unm) else $error("unmapped read not zero");
	property p_irq; msk == 2'h0 && $past(msk) == 2'h0 |-> !irq; endproperty
	a_irq: assert property (p_irq) else $error("interrupt with all sources masked");
	property p_start; $fell(tx_out) && tx_oe |-> !tx_out [*8] ##1 !tx_out [*8]; endproperty
	a_start: assert property (p_start) else $error("low bit shorter than sixteen clocks");
	property p_bit; $rose(tx_out) && tx_oe && $past(tx_oe) |-> tx_out [*8] ##1 tx_out [*8]; endproperty
	a_bit: assert property (p_bit) else $error("high bit shorter than sixteen clocks");
endmodule
`default_nettype wire

// ### tb/usp_line_model.sv
// Remote serial device: frames bytes onto rx, decodes tx
`timescale 1ns/1ps
`default_nettype none
module usp_line_model (
	input wire logic hclk,
	input wire logic tx_out,
	input wire logic tx_oe,
	output logic rx_pin
);
	int bit_clks = 16;
	int got_n = 0;
	int start_len = 0;
	logic [7:0] got = 8'h0;
	logic got_stop = 1'b0;
	initial rx_pin = 1'b1;
	task automatic send(input logic [7:0] b, input logic stp);
		logic [9:0] f;
		f = {stp, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			rx_pin <= f[i];
			repeat (bit_clks) @(posedge hclk);
		end
		rx_pin <= 1'b1;
	endtask
	// Start length only equals one bit when data bit 0 is high
	always begin
		@(negedge tx_out);
		if (tx_oe) begin
			start_len = 0;
			while (!tx_out && start_len < 9999) begin
				@(negedge hclk);
				start_len++;
			end
			repeat (bit_clks / 2) @(negedge hclk);
			for (int i = 0; i < 8; i++) begin
				got[i] = tx_out;
				repeat (bit_clks) @(negedge hclk);
			end
			got_stop = tx_out;
			got_n++;
		end
	end
endmodule
`default_nettype wire

// ### tb/usp_top_tb_top.sv
// Testbench for the serial port block
`timescale 1ns/1ps
`default_nettype none
module usp_top_tb_top;
	import usp_pkg::*;
	localparam int unsigned CLK = 1843200;
	localparam logic [31:0] A_C = {14'h0, USP_IDX_CTRL, 2'h0};
	localparam logic [31:0] A_S = {14'h0, USP_IDX_STAT, 2'h0};
	localparam logic [31:0] A_D = {14'h0, USP_IDX_DATA, 2'h0};
	localparam logic [31:0] A_I = {14'h0, USP_IDX_ISTAT, 2'h0};
	localparam logic [31:0] A_M = {14'h0, USP_IDX_IMASK, 2'h0};
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	usp_ahb_req_s m = '0;
	usp_ahb_req_s req;
	usp_ahb_rsp_s rsp;
	logic rx_pin, tx_out, tx_oe, port_active, irq;
	logic [31:0] v;
	int err_count = 0;
	int total_checks = 0;
	int rate [8] = '{115200, 57600, 38400, 28800, 19200, 14400, 9600, 7200};
	assign req = {m.hsel, m.haddr, m.htrans, m.hwrite, m.hsize, rsp.hreadyout, m.hwdata};
	usp_top #(.CLK_HZ(CLK)) dut (.hclk(hclk), .hresetn(hresetn), .ahb_req(req), .ahb_rsp(rsp),
		.rx_pin(rx_pin), .tx_out(tx_out), .tx_oe(tx_oe), .port_active(port_active), .irq(irq));
	usp_line_model line (.hclk(hclk), .tx_out(tx_out), .tx_oe(tx_oe), .rx_pin(rx_pin));
	initial forever #2 hclk = ~hclk;
	task automatic end_sim;
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e) begin
			err_count++;
			$display("BAD %0t got %h want %h", $time, g, e);
		end
	endtask
	// Values sampled mid-cycle equal what the ending edge takes
	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
		logic ok;
		m.hsel <= 1'b1;
		m.haddr <= a;
		m.hwrite <= w;
		m.hsize <= 3'h2;
		m.htrans <= USP_HTRANS_NONSEQ;
		do begin
			@(negedge hclk);
			ok = rsp.hreadyout;
			@(posedge hclk);
		end while (ok !== 1'b1);
		m.hsel <= 1'b0;
		m.htrans <= 2'h0;
		m.hwdata <= d;
		do begin
			@(negedge hclk);
			ok = rsp.hreadyout;
			r = rsp.hrdata;
			@(posedge hclk);
		end while (ok !== 1'b1);
	endtask
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] x;
		bus(1'b1, a, d, x);
		@(posedge hclk);
	endtask
	task automatic rd(input logic [31:0] a, output logic [31:0] r);
		bus(1'b0, a, 32'h0, r);
	endtask
	task automatic ck_irq(input logic e);
		repeat (2) @(posedge hclk);
		@(negedge hclk);
		chk({31'h0, irq}, {31'h0, e});
		@(posedge hclk);
	endtask
	task automatic wait_tx;
		do rd(A_S, v); while (v[0] !== 1'b0);
	endtask
	task automatic t_regs;
		rd(A_C, v);
		chk(v, 32'h7);
		rd(A_S, v);
		chk(v, 32'h0);
		wr(A_S, 32'h3);
		rd(A_S, v);
		chk(v, 32'h0);
		rd(A_D, v);
		chk(v, 32'h0);
		rd(32'h000303A4, v);
		chk(v, 32'h0);
		$display("regs done");
	endtask
	task automatic t_tx;
		int c, bc, n;
		logic p;
		logic [7:0] b;
		for (int i = 0; i < 9; i++) begin
			c = i % 8;
			p = (i == 8);
			bc = 16 * (CLK / (rate[c] * 16)) * (p ? 8 : 1);
			line.bit_clks = bc;
			b = 8'h31 + 8'(2 * i);
			n = line.got_n;
			wr(A_C, {27'h0, p, 3'(c), 1'b1});
			wr(A_D, {24'h0, b});
			rd(A_S, v);
			chk(v, 32'h1);
			wr(A_D, 32'hFF);
			wait_tx;
			chk(32'(line.got_n - n), 32'h1);
			chk({24'h0, line.got}, {24'h0, b});
			chk({31'h0, line.got_stop}, 32'h1);
			// Start bit aligns to the free-running tick, so it may be up to one tick short
			chk(32'(line.start_len >= bc - bc / 16 + 2 && line.start_len <= bc + 1), 32'h1);
		end
		$display("tx rates done");
	endtask
	task automatic t_irq;
		wr(A_C, 32'h1);
		line.bit_clks = 16;
		rd(A_I, v);
		wr(A_M, 32'h1);
		rd(A_M, v);
		chk(v, 32'h1);
		ck_irq(1'b0);
		wr(A_D, 32'h55);
		wait_tx;
		ck_irq(1'b1);
		rd(A_I, v);
		chk(v, 32'h1);
		ck_irq(1'b0);
		$display("tx irq done");
	endtask
	task automatic t_rx;
		wr(A_M, 32'h0);
		line.send(8'hC3, 1'b1);
		repeat (4) @(posedge hclk);
		rd(A_S, v);
		chk(v, 32'h2);
		ck_irq(1'b0);
		wr(A_M, 32'h2);
		ck_irq(1'b1);
		line.send(8'h5A, 1'b1);
		repeat (4) @(posedge hclk);
		rd(A_D, v);
		chk(v, 32'h5A);
		rd(A_S, v);
		chk(v, 32'h0);
		rd(A_I, v);
		chk(v, 32'h2);
		ck_irq(1'b0);
		line.send(8'h0F, 1'b0);
		repeat (4) @(posedge hclk);
		rd(A_S, v);
		chk(v, 32'h0);
		$display("rx done");
	endtask
	task automatic t_off;
		int n;
		n = line.got_n;
		wr(A_C, 32'h0);
		chk({30'h0, port_active, tx_oe}, 32'h0);
		wr(A_D, 32'h66);
		rd(A_S, v);
		chk(v, 32'h0);
		line.send(8'h77, 1'b1);
		repeat (4) @(posedge hclk);
		rd(A_S, v);
		chk(v, 32'h0);
		chk(32'(line.got_n), 32'(n));
		wr(A_C, 32'h1);
		chk({30'h0, port_active, tx_oe}, 32'h3);
		$display("disable done");
	endtask
	initial begin
		#200000;
		err_count++;
		$display("BAD %0t timeout", $time);
		end_sim;
	end
	initial begin
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		t_regs;
		t_tx;
		t_irq;
		t_rx;
		t_off;
		end_sim;
	end
endmodule
bind usp_top usp_top_sva #(.CLK_HZ(CLK_HZ)) u_sva (.hclk(hclk), .hresetn(hresetn), .ahb_req(ahb_req),
	.ahb_rsp(ahb_rsp), .rx_pin(rx_pin), .tx_out(tx_out), .tx_oe(tx_oe), .port_active(port_active), .irq(irq));
`default_nettype wire
